// [design/alpc_pkg.sv]
// package for the converter low-power control block
// Summary of operation
// - stop3 without async clock aborts conversion
// - stop3 entry and exit keep results
// - after abort, idle until new trigger
// - async clock selected: keep running in stop3
// - async clock selected: running conversion completes during stop3
// - stop3 starts by hardware trigger or continuous
// - completion sets flag, enabled interrupt wakes
// - stop1/stop2 disables, registers return to reset
// - config: lp 7, div 6:5, ls 4, mode 3:2, clk 1:0
// - mode 10 selects ten-bit conversions
// - clock 00 is bus clock, divider 00 undivided
// - long sample select 1 uses long sampling
// - control two: active 7, trigger 6, cmp 5, dir 4
// - control two bits 3:0 read zero
// - control one: flag 7, irq 6, cont 5, chan 4:0
// - continuous 0 gives one conversion per trigger, repeated while a ten-bit result is blocked
// - channel 00001 routes analog input one
// - compare value registers feed compare function
// - pin control bit disables pin digital I/O
// - ten-bit blocking between high and low reads
// - direction 1 flags >= value, 0 flags below
package alpc_pkg;
    localparam logic [11:0] ALPC_OFS_STATUS_ONE = 12'h000;
    localparam logic [11:0] ALPC_OFS_STATUS_TWO = 12'h004;
    localparam logic [11:0] ALPC_OFS_RES_HIGH   = 12'h008;
    localparam logic [11:0] ALPC_OFS_RES_LOW    = 12'h00c;
    localparam logic [11:0] ALPC_OFS_CMP_HIGH   = 12'h010;
    localparam logic [11:0] ALPC_OFS_CMP_LOW    = 12'h014;
    localparam logic [11:0] ALPC_OFS_CONFIG     = 12'h018;
    localparam logic [11:0] ALPC_OFS_PIN_CTRL   = 12'h01c;
    localparam logic [11:0] ALPC_OFS_POWER      = 12'h020;
    localparam int ALPC_LP_BIT    = 7;
    localparam int ALPC_DIV_LSB   = 5;
    localparam int ALPC_LS_BIT    = 4;
    localparam int ALPC_MODE_LSB  = 2;
    localparam int ALPC_CLK_LSB   = 0;
    localparam int ALPC_ACT_BIT   = 7;
    localparam int ALPC_TRG_BIT   = 6;
    localparam int ALPC_CFE_BIT   = 5;
    localparam int ALPC_CGT_BIT   = 4;
    localparam int ALPC_CONV_COMPLETE_FLAG_BIT  = 7;
    localparam int ALPC_IEN_BIT   = 6;
    localparam int ALPC_CO_BIT    = 5;
    localparam logic [1:0] ALPC_MODE_8  = 2'h0;
    localparam logic [1:0] ALPC_MODE_10 = 2'h2;
    localparam logic [1:0] ALPC_CLK_BUS = 2'h0;
    localparam logic [1:0] ALPC_CLK_ASYNC = 2'h3;
    localparam logic [4:0] ALPC_CH_OFF  = 5'h1f;
    localparam logic [7:0] ALPC_RST_SC1 = 8'h1f;
    localparam logic [7:0] ALPC_RST_REG = 8'h00;
    localparam logic [5:0] ALPC_SHORT_CYC = 6'h04;
    localparam logic [5:0] ALPC_LONG_CYC  = 6'h18;
    localparam logic [3:0] ALPC_SAR_10 = 4'ha;
    localparam logic [3:0] ALPC_SAR_8  = 4'h8;
    typedef enum logic [1:0] {ALPC_IDLE, ALPC_SAMPLE, ALPC_CONVERT} alpc_state_t;
endpackage

// [design/alpc_ctrl.sv]
// converter control block with stop mode handling and apb registers
`timescale 1ns/1ps
module alpc_ctrl
    import alpc_pkg::*;
#(
    parameter int DATA_W = 10
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              stop3_mode,
    input  wire logic              stop12_mode,
    input  wire logic              hw_trigger,
    input  wire logic [DATA_W-1:0] sample_data,
    input  wire logic              async_conv_clock_tick,
    output logic                   conv_irq,
    output logic                   conv_clock_run,
    output logic [4:0]             channel_select,
    output logic                   long_sample_select,
    output logic                   low_power_select,
    output logic [7:0]             pin_digital_disable
);
    logic [7:0]            conversion_config;
    logic [7:0]            control_status_two;
    logic [7:0]            control_status_one;
    logic [7:0]            compare_value_high;
    logic [7:0]            compare_value_low;
    logic [7:0]            analog_pin_ctrl_one;
    logic [DATA_W-1:0]     result;
    logic                  high_read;
    alpc_state_t           state;
    logic [5:0]            count;
    logic [1:0]            div_cnt;
    logic                  conv_tick;
    logic                  wr;
    logic                  rd;
    logic                  async_sel;
    logic                  abort;
    logic                  done;
    logic                  start;
    logic                  ten_bit;
    logic                  blocked;
    logic                  cmp_hit;
    logic [DATA_W-1:0]     cmp_value;
    logic [DATA_W-1:0]     diff;
    logic                  hw_trg_q;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    assign wr       = psel && penable && pwrite;
    assign rd       = psel && penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign async_sel = conversion_config[ALPC_CLK_LSB +: 2] == ALPC_CLK_ASYNC;
    assign ten_bit  = conversion_config[ALPC_MODE_LSB +: 2] == ALPC_MODE_10;
    assign abort    = (stop3_mode && !async_sel)
                    || (wr && !hit(paddr, ALPC_OFS_RES_HIGH) && !hit(paddr, ALPC_OFS_RES_LOW)
                        && !hit(paddr, ALPC_OFS_PIN_CTRL) && !hit(paddr, ALPC_OFS_POWER));
    // async clock keeps ticking in stop3, bus-derived clock stops
    assign conv_tick = async_sel ? async_conv_clock_tick
                                 : (div_cnt == 2'h0);
    assign conv_clock_run     = state != ALPC_IDLE;
    assign channel_select     = control_status_one[4:0];
    assign long_sample_select = conversion_config[ALPC_LS_BIT];
    assign low_power_select   = conversion_config[ALPC_LP_BIT];
    assign pin_digital_disable = analog_pin_ctrl_one;
    assign conv_irq = control_status_one[ALPC_CONV_COMPLETE_FLAG_BIT]
                   && control_status_one[ALPC_IEN_BIT];
    assign cmp_value = DATA_W'({compare_value_high, compare_value_low});
    assign diff      = sample_data - cmp_value;
    assign cmp_hit   = control_status_two[ALPC_CGT_BIT] ? (sample_data >= cmp_value)
                                                        : (sample_data < cmp_value);
    assign blocked   = ten_bit && high_read;
    assign done      = state == ALPC_CONVERT && conv_tick && count == 6'h0;
    // sc1 write starts unless channel all ones, else hardware trigger rising edge with trigger bit set
    assign start = (wr && hit(paddr, ALPC_OFS_STATUS_ONE) && pwdata[4:0] != ALPC_CH_OFF)
                || (control_status_two[ALPC_TRG_BIT] && hw_trigger && !hw_trg_q
                    && channel_select != ALPC_CH_OFF);

    // divider counter from bus clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt <= 2'h0;
        else if (div_cnt >= conversion_config[ALPC_DIV_LSB +: 2])
            div_cnt <= 2'h0;
        else
            div_cnt <= div_cnt + 2'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hw_trg_q <= 1'b0;
        else
            hw_trg_q <= hw_trigger;
    end

    // conversion sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ALPC_IDLE;
            count <= 6'h0;
        end
        else if (stop12_mode || (stop3_mode && !async_sel) || (abort && !start))
        begin
            state <= ALPC_IDLE;
            count <= 6'h0;
        end
        // control write that also starts: abort, then restart sampling
        else if (abort)
        begin
            state <= ALPC_SAMPLE;
            count <= long_sample_select ? ALPC_LONG_CYC : ALPC_SHORT_CYC;
        end
        else
        begin
            unique case (state)
                ALPC_IDLE:
                begin
                    if (start)
                    begin
                        state <= ALPC_SAMPLE;
                        count <= long_sample_select ? ALPC_LONG_CYC : ALPC_SHORT_CYC;
                    end
                end
                ALPC_SAMPLE:
                begin
                    if (conv_tick)
                    begin
                        if (count == 6'h0)
                        begin
                            state <= ALPC_CONVERT;
                            count <= {2'h0, ten_bit ? ALPC_SAR_10 : ALPC_SAR_8};
                        end
                        else
                            count <= count - 6'h1;
                    end
                end
                ALPC_CONVERT:
                begin
                    if (conv_tick)
                    begin
                        if (count != 6'h0)
                            count <= count - 6'h1;
                        else if (control_status_two[ALPC_CFE_BIT] && !cmp_hit && !blocked
                                 && !control_status_one[ALPC_CO_BIT])
                            state <= ALPC_IDLE;
                        else if (control_status_one[ALPC_CO_BIT] || blocked)
                        begin
                            state <= ALPC_SAMPLE;
                            count <= long_sample_select ? ALPC_LONG_CYC : ALPC_SHORT_CYC;
                        end
                        else
                            state <= ALPC_IDLE;
                    end
                end
                default:
                    state <= ALPC_IDLE;
            endcase
        end
    end

    // result register kept through stop3, cleared only by reset and stop1/stop2
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result <= '0;
        else if (stop12_mode)
            result <= '0;
        else if (done && !blocked && (!control_status_two[ALPC_CFE_BIT] || cmp_hit))
            result <= control_status_two[ALPC_CFE_BIT] ? diff : sample_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            high_read <= 1'b0;
        else if (stop12_mode || (rd && hit(paddr, ALPC_OFS_RES_LOW)))
            high_read <= 1'b0;
        else if (rd && hit(paddr, ALPC_OFS_RES_HIGH))
            high_read <= 1'b1;
    end

    // register writes, stop1/stop2 returns all to reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conversion_config   <= ALPC_RST_REG;
            compare_value_high  <= ALPC_RST_REG;
            compare_value_low   <= ALPC_RST_REG;
            analog_pin_ctrl_one <= ALPC_RST_REG;
        end
        else if (stop12_mode)
        begin
            conversion_config   <= ALPC_RST_REG;
            compare_value_high  <= ALPC_RST_REG;
            compare_value_low   <= ALPC_RST_REG;
            analog_pin_ctrl_one <= ALPC_RST_REG;
        end
        else if (wr)
        begin
            if (hit(paddr, ALPC_OFS_CONFIG))
                conversion_config <= pwdata[7:0];
            if (hit(paddr, ALPC_OFS_CMP_HIGH))
                compare_value_high <= pwdata[7:0];
            if (hit(paddr, ALPC_OFS_CMP_LOW))
                compare_value_low <= pwdata[7:0];
            if (hit(paddr, ALPC_OFS_PIN_CTRL))
                analog_pin_ctrl_one <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_status_two <= ALPC_RST_REG;
        else if (stop12_mode)
            control_status_two <= ALPC_RST_REG;
        else
        begin
            if (wr && hit(paddr, ALPC_OFS_STATUS_TWO))
                control_status_two[6:4] <= pwdata[6:4];
            control_status_two[ALPC_ACT_BIT] <= conv_clock_run;
            control_status_two[3:0] <= 4'h0;
        end
    end

    // completion flag: set wins over write clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_status_one <= ALPC_RST_SC1;
        else if (stop12_mode)
            control_status_one <= ALPC_RST_SC1;
        else
        begin
            if (wr && hit(paddr, ALPC_OFS_STATUS_ONE))
                control_status_one[6:0] <= pwdata[6:0];
            if (done && !blocked && (!control_status_two[ALPC_CFE_BIT] || cmp_hit))
                control_status_one[ALPC_CONV_COMPLETE_FLAG_BIT] <= 1'b1;
            else if ((wr && hit(paddr, ALPC_OFS_STATUS_ONE))
                     || (rd && hit(paddr, ALPC_OFS_RES_LOW)))
                control_status_one[ALPC_CONV_COMPLETE_FLAG_BIT] <= 1'b0;
        end
    end

    // read mux, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (1'b1)
                hit(paddr, ALPC_OFS_STATUS_ONE): prdata <= {24'h0, control_status_one};
                hit(paddr, ALPC_OFS_STATUS_TWO): prdata <= {24'h0, control_status_two};
                hit(paddr, ALPC_OFS_RES_HIGH):
                    prdata <= {24'h0, 8'(result >> 8)};
                hit(paddr, ALPC_OFS_RES_LOW):    prdata <= {24'h0, result[7:0]};
                hit(paddr, ALPC_OFS_CMP_HIGH):   prdata <= {24'h0, compare_value_high};
                hit(paddr, ALPC_OFS_CMP_LOW):    prdata <= {24'h0, compare_value_low};
                hit(paddr, ALPC_OFS_CONFIG):     prdata <= {24'h0, conversion_config};
                hit(paddr, ALPC_OFS_PIN_CTRL):   prdata <= {24'h0, analog_pin_ctrl_one};
                hit(paddr, ALPC_OFS_POWER):
                    prdata <= {30'h0, stop12_mode, stop3_mode};
                default:                         prdata <= 32'h0000_0000;
            endcase
        end
    end

    abort_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (stop3_mode && !async_sel) |=> state == ALPC_IDLE)
        else $error("stop3 without async clock did not abort");

    result_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(stop3_mode) && !done |=> $stable(result))
        else $error("result changed on stop3 entry");

    stop3_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        stop3_mode && !stop12_mode && !done |=> $stable(result))
        else $error("result changed during stop3");

    idle_stay_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ALPC_IDLE && !start |=> state == ALPC_IDLE)
        else $error("left idle without trigger");

    async_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        stop3_mode && async_sel && !stop12_mode && !wr && state == ALPC_SAMPLE
        |=> state != ALPC_IDLE)
        else $error("async conversion aborted in stop3");

    hw_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ALPC_IDLE && control_status_two[ALPC_TRG_BIT] && hw_trigger && !hw_trg_q
        && channel_select != ALPC_CH_OFF && !stop12_mode && !(stop3_mode && !async_sel)
        |=> state == ALPC_SAMPLE)
        else $error("hardware trigger did not start");

    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !blocked && !stop12_mode && !control_status_two[ALPC_CFE_BIT]
        |=> control_status_one[ALPC_CONV_COMPLETE_FLAG_BIT])
        else $error("completion flag not set");

    stop12_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        stop12_mode |=> conversion_config == ALPC_RST_REG && state == ALPC_IDLE)
        else $error("stop1/stop2 did not reset");

    stop12_sc1_a: assert property (@(posedge pclk) disable iff (!presetn)
        stop12_mode |=> control_status_one == ALPC_RST_SC1 && result == '0)
        else $error("stop1/stop2 left control one or result");

    cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit(paddr, ALPC_OFS_CONFIG) && !stop12_mode
        |=> conversion_config == $past(pwdata[7:0]))
        else $error("config write lost");

    ten_bit_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ALPC_SAMPLE && conv_tick && count == 6'h0 && ten_bit && !stop12_mode && !abort
        |=> state == ALPC_CONVERT && count == {2'h0, ALPC_SAR_10})
        else $error("ten-bit step count wrong");

    long_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        start && (abort || state == ALPC_IDLE) && !stop12_mode && !(stop3_mode && !async_sel)
        && long_sample_select |=> state == ALPC_SAMPLE && count == ALPC_LONG_CYC)
        else $error("long sample count wrong");

    short_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        start && (abort || state == ALPC_IDLE) && !stop12_mode && !(stop3_mode && !async_sel)
        && !long_sample_select |=> state == ALPC_SAMPLE && count == ALPC_SHORT_CYC)
        else $error("short sample count wrong");

    act_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        !stop12_mode |=> control_status_two[ALPC_ACT_BIT] == $past(conv_clock_run))
        else $error("active flag wrong");

    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        control_status_two[3:0] == 4'h0)
        else $error("reserved bits nonzero");

    single_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !blocked && !control_status_one[ALPC_CO_BIT] && !stop12_mode && !abort
        |=> state == ALPC_IDLE)
        else $error("single conversion did not stop");

    cont_next_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && control_status_one[ALPC_CO_BIT] && !stop12_mode && !abort
        |=> state == ALPC_SAMPLE)
        else $error("continuous conversion did not restart");

    pin_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit(paddr, ALPC_OFS_PIN_CTRL) && !stop12_mode
        |=> pin_digital_disable == $past(pwdata[7:0]))
        else $error("pin control write lost");

    block_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && blocked && !stop12_mode |=> $stable(result))
        else $error("blocked result overwritten");

    high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(paddr, ALPC_OFS_RES_HIGH) && !stop12_mode |=> high_read)
        else $error("high read not noted");

    low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(paddr, ALPC_OFS_RES_LOW) |=> !high_read)
        else $error("low read did not clear blocking");

    cmp_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && control_status_two[ALPC_CFE_BIT] && !cmp_hit |=> $stable(result))
        else $error("failed compare stored result");
endmodule // alpc_ctrl

// [verification/alpc_ctrl_bench.sv]
// self-checking bench for the converter low-power control block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module alpc_ctrl_bench;
    import alpc_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        stop3_mode;
    logic        stop12_mode;
    logic        hw_trigger;
    logic [9:0]  sample_data;
    logic        async_conv_clock_tick;
    logic        tick_en;
    logic        conv_irq;
    logic        conv_clock_run;
    logic [4:0]  channel_select;
    logic        long_sample_select;
    logic        low_power_select;
    logic [7:0]  pin_digital_disable;
    int          n_errors = 0;
    int          check_count = 0;

    alpc_ctrl alpc_ctrl_inst (
        .pclk                  (pclk),
        .presetn               (presetn),
        .psel                  (psel),
        .penable               (penable),
        .pwrite                (pwrite),
        .paddr                 (paddr),
        .pwdata                (pwdata),
        .prdata                (prdata),
        .pready                (pready),
        .pslverr               (pslverr),
        .stop3_mode            (stop3_mode),
        .stop12_mode           (stop12_mode),
        .hw_trigger            (hw_trigger),
        .sample_data           (sample_data),
        .async_conv_clock_tick (async_conv_clock_tick),
        .conv_irq              (conv_irq),
        .conv_clock_run        (conv_clock_run),
        .channel_select        (channel_select),
        .long_sample_select    (long_sample_select),
        .low_power_select      (low_power_select),
        .pin_digital_disable   (pin_digital_disable)
    );

    always #50 pclk = ~pclk;

    // async conversion clock, one pulse every other bus cycle
    always @(posedge pclk)
        async_conv_clock_tick <= tick_en & ~async_conv_clock_tick;

    task automatic print_verdict();
        $display("counts: checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic fail_out();
        n_errors++;
        print_verdict();
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        if (i == 16)
            fail_out();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask

    // poll the complete flag a bounded number of times
    task automatic wait_flag(input int n, input logic exp);
        logic [31:0] q;
        logic        hit;
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++)
        begin
            apb(1'b0, ALPC_OFS_STATUS_ONE, 32'h0000_0000, q);
            hit = (q[ALPC_CONV_COMPLETE_FLAG_BIT] === 1'b1);
        end
        if (exp && !hit)
            fail_out();
        `CHK(hit, exp)
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        stop3_mode = 1'b0;
        stop12_mode = 1'b0;
        hw_trigger = 1'b0;
        sample_data = 10'h2a5;
        tick_en = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(channel_select, 5'h1f)
        rd(ALPC_OFS_STATUS_ONE, 32'h0000_001f);
        rd(ALPC_OFS_CONFIG, 32'h0000_0000);
        $display("test reset values done");
        wr(ALPC_OFS_CONFIG, 32'h0000_0098);
        wr(ALPC_OFS_STATUS_TWO, 32'h0000_0000);
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0041);
        `CHK({low_power_select, long_sample_select, channel_select}, 7'h61)
        rd(ALPC_OFS_CONFIG, 32'h0000_0098);
        rd(ALPC_OFS_STATUS_TWO, 32'h0000_0080);
        wait_flag(40, 1'b1);
        `CHK(conv_irq, 1'b1)
        rd(ALPC_OFS_RES_HIGH, 32'h0000_0002);
        rd(ALPC_OFS_RES_LOW, 32'h0000_00a5);
        `CHK(conv_clock_run, 1'b0)
        rd(ALPC_OFS_STATUS_ONE, 32'h0000_0041);
        wr(ALPC_OFS_STATUS_TWO, 32'h0000_00fc);
        rd(ALPC_OFS_STATUS_TWO, 32'h0000_0070);
        wr(12'h100, 32'h0000_00ff);
        rd(12'h100, 32'h0000_0000);
        wr(ALPC_OFS_STATUS_TWO, 32'h0000_0000);
        $display("test init and single conversion done");
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0041);
        `CHK(conv_clock_run, 1'b1)
        stop3_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(conv_clock_run, 1'b0)
        rd(ALPC_OFS_RES_HIGH, 32'h0000_0002);
        stop3_mode <= 1'b0;
        repeat (60) @(posedge pclk);
        `CHK(conv_clock_run, 1'b0)
        rd(ALPC_OFS_RES_LOW, 32'h0000_00a5);
        rd(ALPC_OFS_STATUS_ONE, 32'h0000_0041);
        $display("test stop3 abort done");
        rd(ALPC_OFS_RES_LOW, 32'h0000_00a5);
        tick_en <= 1'b1;
        sample_data <= 10'h13c;
        wr(ALPC_OFS_CONFIG, 32'h0000_000b);
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0061);
        stop3_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(conv_clock_run, 1'b1)
        wait_flag(60, 1'b1);
        `CHK(conv_irq, 1'b1)
        rd(ALPC_OFS_RES_HIGH, 32'h0000_0001);
        sample_data <= 10'h3c3;
        rd(ALPC_OFS_RES_LOW, 32'h0000_003c);
        wait_flag(60, 1'b1);
        rd(ALPC_OFS_RES_HIGH, 32'h0000_0003);
        rd(ALPC_OFS_RES_LOW, 32'h0000_00c3);
        sample_data <= 10'h0f0;
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0041);
        wr(ALPC_OFS_STATUS_TWO, 32'h0000_0040);
        `CHK(conv_clock_run, 1'b0)
        hw_trigger <= 1'b1;
        repeat (2) @(posedge pclk);
        hw_trigger <= 1'b0;
        wait_flag(60, 1'b1);
        rd(ALPC_OFS_RES_LOW, 32'h0000_00f0);
        stop3_mode <= 1'b0;
        tick_en <= 1'b0;
        $display("test stop3 with async clock done");
        sample_data <= 10'h2a5;
        wr(ALPC_OFS_CONFIG, 32'h0000_0008);
        wr(ALPC_OFS_CMP_HIGH, 32'h0000_0001);
        wr(ALPC_OFS_CMP_LOW, 32'h0000_0000);
        wr(ALPC_OFS_STATUS_TWO, 32'h0000_0030);
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0001);
        wait_flag(40, 1'b1);
        rd(ALPC_OFS_RES_HIGH, 32'h0000_0001);
        rd(ALPC_OFS_RES_LOW, 32'h0000_00a5);
        wr(ALPC_OFS_STATUS_TWO, 32'h0000_0020);
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0001);
        wait_flag(30, 1'b0);
        $display("test compare done");
        sample_data <= 10'h155;
        wr(ALPC_OFS_STATUS_TWO, 32'h0000_0000);
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0001);
        wait_flag(40, 1'b1);
        rd(ALPC_OFS_RES_HIGH, 32'h0000_0001);
        sample_data <= 10'h0aa;
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0001);
        repeat (40) @(posedge pclk);
        rd(ALPC_OFS_STATUS_ONE, 32'h0000_0001);
        rd(ALPC_OFS_RES_LOW, 32'h0000_0055);
        $display("test result blocking done");
        wr(ALPC_OFS_PIN_CTRL, 32'h0000_0002);
        `CHK(pin_digital_disable, 8'h02)
        wr(ALPC_OFS_CONFIG, 32'h0000_0098);
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0041);
        stop12_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(conv_clock_run, 1'b0)
        stop12_mode <= 1'b0;
        @(posedge pclk);
        rd(ALPC_OFS_CONFIG, 32'h0000_0000);
        rd(ALPC_OFS_PIN_CTRL, 32'h0000_0000);
        rd(ALPC_OFS_STATUS_ONE, 32'h0000_001f);
        rd(ALPC_OFS_RES_LOW, 32'h0000_0000);
        `CHK(pin_digital_disable, 8'h00)
        sample_data <= 10'h2a5;
        wr(ALPC_OFS_CONFIG, 32'h0000_0008);
        wr(ALPC_OFS_STATUS_TWO, 32'h0000_0000);
        wr(ALPC_OFS_STATUS_ONE, 32'h0000_0001);
        wait_flag(40, 1'b1);
        rd(ALPC_OFS_RES_HIGH, 32'h0000_0002);
        rd(ALPC_OFS_RES_LOW, 32'h0000_00a5);
        $display("test stop1 stop2 done");
        print_verdict();
    end
endmodule // alpc_ctrl_bench
